// [core/tofs_params.svh]
// Offsets, field positions, reset values and timing counts for the turn-off/summary bank
`ifndef TOFS_PARAMS_SVH
`define TOFS_PARAMS_SVH
`define TOFS_CMD_DELAY_TIME 8'h64
`define TOFS_CMD_FALL_TIME 8'h65
`define TOFS_CMD_SUMMARY 8'h78
`define TOFS_CMD_STATUS_WORD 8'h79
`define TOFS_MANT_W 7
`define TOFS_MANT_RESET 7'h00
`define TOFS_MS_W 7
`define TOFS_CLK_HZ 50000000
`define TOFS_TICK_MS 1
`define TOFS_CYC_PER_MS ((`TOFS_CLK_HZ / 1000) * `TOFS_TICK_MS)
`define TOFS_PRE_W 16
`define TOFS_FALL_MIN_MS 7'h01
`define TOFS_SUM_OFF 6
`define TOFS_SUM_OVERVOLT 5
`define TOFS_SUM_OVERCUR 4
`define TOFS_SUM_TEMP 2
`define TOFS_SUM_COMM 1
`define TOFS_SUM_OTH 0
`define TOFS_SRC_BIT 7
`define TOFS_MAP_BKT_N 16
`endif

// [core/tofs_pkg.sv]
// Types for the turn-off timing and fault summary bank
`default_nettype none
package tofs_pkg;
    typedef enum logic [1:0] {TOFS_IDLE, TOFS_DELAY, TOFS_FALL} tofs_seq_t;
    typedef logic [7:0] tofs_byte_t;
endpackage : tofs_pkg
`default_nettype wire

// [core/tofs_setting_mem.sv]
// Two-word store for the programmable turn-off mantissas, registered read data
`default_nettype none
`include "tofs_params.svh"
module tofs_setting_mem (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic wrEn,
    input wire logic wrSel,
    input wire logic [`TOFS_MANT_W-1:0] wrData,
    input wire logic rdSel,
    output logic [`TOFS_MANT_W-1:0] rdData,
    output logic [`TOFS_MANT_W-1:0] delayMant,
    output logic [`TOFS_MANT_W-1:0] fallMant
);
    import tofs_pkg::*;
    logic [`TOFS_MANT_W-1:0] word_r [2];

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            word_r[0] <= `TOFS_MANT_RESET;
            word_r[1] <= `TOFS_MANT_RESET;
        end else if (wrEn) begin
            word_r[wrSel] <= wrData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rdData <= `TOFS_MANT_RESET;
        end else begin
            rdData <= (wrEn && wrSel == rdSel) ? wrData : word_r[rdSel];
        end
    end

    assign delayMant = word_r[0];
    assign fallMant = word_r[1];
endmodule : tofs_setting_mem
`default_nettype wire

// [core/tofs_turnoff_summary.sv]
// Turn-off delay/fall registers, turn-off sequencer and fault summary byte
// Behaviour
// - Exponent fixed zero, writes to it ignored.
// - Upper mantissa reads zero; low seven writable.
// - Only sixteen effective delay durations exist.
// - Delay mantissa maps through bucket table.
// - Delay counted from stop to fall start.
// - Ramp down over effective fall time.
// - Fall mantissa zero ramps in 1 ms.
// - Fall uses delay table, minimum 1 ms.
// - Loop slave access NACKed, flags fault, alerts.
// - Store-all copies both settings to memory.
// - Summary byte bit layout; bits 7,3 zero.
// - Off flag set while converter disabled.
// - Overvoltage mirrors voltage status bit 7, forced zero while loop slave.
// - Overcurrent mirrors current status bit 7.
// - Masking through source status bits; loop slave also masks overvoltage.
// - Summary writes ignored; clears follow sources.
// - Temperature bit ORs temperature status.
// - Comm bit ORs communication status.
// - Other bit ORs listed minor conditions.
// - Other bit reads one after reset; here it has no reset value and reads one only while a listed source is set.
// - Status word low byte equals summary.
`default_nettype none
`include "tofs_params.svh"
module tofs_turnoff_summary (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic loopSlave,
    input wire logic cmdValid,
    input wire logic cmdWrite,
    input wire logic [7:0] cmdCode,
    input wire logic [15:0] cmdWrData,
    output logic cmdAck,
    output logic cmdNack,
    output logic [15:0] cmdRdData,
    output logic cmdRdValid,
    output logic invalidCmdFault,
    output logic smbAlertReq,
    input wire logic storeAll,
    output logic nvmWrEn,
    output logic [15:0] nvmDelayWord,
    output logic [15:0] nvmFallWord,
    input wire logic stopReq,
    output logic rampActive,
    output logic fallActive,
    output logic [6:0] fallMsOut,
    input wire logic convEnabled,
    input wire tofs_pkg::tofs_byte_t output_voltage_status,
    input wire tofs_pkg::tofs_byte_t output_current_status,
    input wire tofs_pkg::tofs_byte_t temperature_status,
    input wire tofs_pkg::tofs_byte_t communication_status,
    input wire logic undervoltFault,
    input wire logic overcurrentWarn,
    input wire logic overvoltWarn,
    input wire logic undervoltWarn,
    input wire logic turn_on_timeout_fault,
    input wire logic lowInputVoltage,
    input wire logic setpoint_limit_warning,
    input wire logic bandgap_overtemp_fault,
    input wire logic internal_supply_fault,
    output tofs_pkg::tofs_byte_t faultSummary,
    output logic [15:0] statusWordLow
);
    import tofs_pkg::*;

    // Bucket table; 0 stays 0 so the fall path applies its own floor
    function automatic logic [`TOFS_MS_W-1:0] bucketMs(input logic [`TOFS_MANT_W-1:0] m);
        if (m <= 7'd6) bucketMs = m;
        else if (m <= 7'd9) bucketMs = 7'd7;
        else if (m <= 7'd12) bucketMs = 7'd10;
        else if (m <= 7'd17) bucketMs = 7'd14;
        else if (m <= 7'd22) bucketMs = 7'd19;
        else if (m <= 7'd32) bucketMs = 7'd27;
        else if (m <= 7'd44) bucketMs = 7'd37;
        else if (m <= 7'd62) bucketMs = 7'd52;
        else if (m <= 7'd86) bucketMs = 7'd72;
        else bucketMs = 7'd100;
    endfunction : bucketMs

    function automatic logic [15:0] linWord(input logic [`TOFS_MANT_W-1:0] m);
        linWord = {9'h000, m};
    endfunction : linWord

    logic isTurnoff;
    logic hit;
    logic memWr;
    logic [`TOFS_MANT_W-1:0] memRd;
    logic [`TOFS_MANT_W-1:0] delayMant;
    logic [`TOFS_MANT_W-1:0] fallMant;
    logic [`TOFS_MS_W-1:0] delayMs;
    logic [`TOFS_MS_W-1:0] fallMs;
    logic rdPend_r;
    logic rdIsSetting_r;
    tofs_byte_t sumHold_r;

    assign isTurnoff = cmdCode == `TOFS_CMD_DELAY_TIME || cmdCode == `TOFS_CMD_FALL_TIME;
    assign hit = isTurnoff || (!cmdWrite && (cmdCode == `TOFS_CMD_SUMMARY || cmdCode == `TOFS_CMD_STATUS_WORD));
    // Loop slave locks out both turn-off commands entirely
    assign memWr = cmdValid && cmdWrite && isTurnoff && !loopSlave;
    assign cmdNack = cmdValid && isTurnoff && loopSlave;
    // Summary writes are not ours to take; left to the command decoder
    assign cmdAck = cmdValid && hit && !cmdNack;

    tofs_setting_mem uMem (
        .core_clk(core_clk),
        .resetn(resetn),
        .wrEn(memWr),
        .wrSel(cmdCode == `TOFS_CMD_FALL_TIME),
        .wrData(cmdWrData[`TOFS_MANT_W-1:0]),
        .rdSel(cmdCode == `TOFS_CMD_FALL_TIME),
        .rdData(memRd),
        .delayMant(delayMant),
        .fallMant(fallMant)
    );

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            invalidCmdFault <= 1'b0;
            smbAlertReq <= 1'b0;
        end else begin
            invalidCmdFault <= cmdNack;
            smbAlertReq <= cmdNack;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rdPend_r <= 1'b0;
            rdIsSetting_r <= 1'b0;
        end else begin
            rdPend_r <= cmdValid && !cmdWrite && cmdAck;
            rdIsSetting_r <= isTurnoff;
        end
    end

    assign cmdRdValid = rdPend_r;
    assign cmdRdData = rdIsSetting_r ? linWord(memRd) : {8'h00, sumHold_r};

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            nvmWrEn <= 1'b0;
            nvmDelayWord <= 16'h0000;
            nvmFallWord <= 16'h0000;
        end else begin
            nvmWrEn <= storeAll;
            if (storeAll) begin
                nvmDelayWord <= linWord(delayMant);
                nvmFallWord <= linWord(fallMant);
            end
        end
    end

    // Sequencer
    assign delayMs = bucketMs(delayMant);
    // Zero means fastest ramp, which is 1 ms
    assign fallMs = (fallMant <= 7'd1) ? `TOFS_FALL_MIN_MS : bucketMs(fallMant);

    localparam int unsigned CycPerMs = `TOFS_CYC_PER_MS;
    logic [`TOFS_PRE_W-1:0] pre_r;
    logic msTick;
    tofs_seq_t seq_r;
    logic [`TOFS_MS_W-1:0] msLeft_r;

    assign msTick = pre_r == `TOFS_PRE_W'(CycPerMs - 1);

    always_ff @(posedge core_clk) begin
        if (!resetn || seq_r == TOFS_IDLE) begin
            pre_r <= '0;
        end else begin
            pre_r <= msTick ? '0 : pre_r + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            seq_r <= TOFS_IDLE;
            msLeft_r <= '0;
        end else begin
            unique case (seq_r)
                TOFS_IDLE: begin
                    if (stopReq) begin
                        if (delayMs == '0) begin
                            seq_r <= TOFS_FALL;
                            msLeft_r <= fallMs;
                        end else begin
                            seq_r <= TOFS_DELAY;
                            msLeft_r <= delayMs;
                        end
                    end
                end
                TOFS_DELAY: begin
                    if (msTick) begin
                        if (msLeft_r == 7'd1) begin
                            seq_r <= TOFS_FALL;
                            msLeft_r <= fallMs;
                        end else begin
                            msLeft_r <= msLeft_r - 1'b1;
                        end
                    end
                end
                TOFS_FALL: begin
                    if (msTick) begin
                        if (msLeft_r == 7'd1) seq_r <= TOFS_IDLE;
                        else msLeft_r <= msLeft_r - 1'b1;
                    end
                end
            endcase
        end
    end

    assign rampActive = seq_r != TOFS_IDLE;
    assign fallActive = seq_r == TOFS_FALL;

    always_ff @(posedge core_clk) begin
        if (!resetn) fallMsOut <= `TOFS_FALL_MIN_MS;
        else fallMsOut <= fallMs;
    end

    // Summary byte; combinational, but command reads return the copy registered at the taking edge
    tofs_byte_t sumNow;
    always_comb begin
        sumNow = 8'h00;
        sumNow[`TOFS_SUM_OFF] = !convEnabled;
        // Masks live in the source registers; only loop slave gates overvoltage here
        sumNow[`TOFS_SUM_OVERVOLT] = output_voltage_status[`TOFS_SRC_BIT] && !loopSlave;
        sumNow[`TOFS_SUM_OVERCUR] = output_current_status[`TOFS_SRC_BIT];
        sumNow[`TOFS_SUM_TEMP] = |temperature_status;
        sumNow[`TOFS_SUM_COMM] = |communication_status;
        sumNow[`TOFS_SUM_OTH] = undervoltFault | overcurrentWarn | overvoltWarn | undervoltWarn
            | turn_on_timeout_fault | lowInputVoltage | setpoint_limit_warning
            | bandgap_overtemp_fault | internal_supply_fault;
    end
    assign faultSummary = sumNow;
    assign statusWordLow = {8'h00, sumNow};

    always_ff @(posedge core_clk) begin
        if (!resetn) sumHold_r <= 8'h00;
        else sumHold_r <= sumNow;
    end

    chk_nack_no_write: assert property (@(posedge core_clk) disable iff (!resetn)
        cmdValid && loopSlave && isTurnoff |-> !memWr ##1 invalidCmdFault && smbAlertReq)
        else $error("loop slave access not refused");
    chk_loop_keeps: assert property (@(posedge core_clk) disable iff (!resetn)
        cmdValid && loopSlave && isTurnoff |=> $stable(delayMant) && $stable(fallMant))
        else $error("loop slave access changed a setting");
    chk_exp_zero: assert property (@(posedge core_clk) disable iff (!resetn)
        cmdRdValid && rdIsSetting_r |-> cmdRdData[15:7] == 9'h000)
        else $error("exponent or upper mantissa nonzero");
    chk_write_lands: assert property (@(posedge core_clk) disable iff (!resetn)
        cmdValid && cmdWrite && cmdCode == `TOFS_CMD_DELAY_TIME && !loopSlave
        |=> delayMant == $past(cmdWrData[`TOFS_MANT_W-1:0]))
        else $error("delay write did not land");
    chk_fall_floor: assert property (@(posedge core_clk) disable iff (!resetn)
        fallMant <= 7'd1 |-> fallMs == 7'd1)
        else $error("fall floor wrong");
    chk_fall_table: assert property (@(posedge core_clk) disable iff (!resetn)
        fallMant > 7'h56 |-> fallMs == 7'h64)
        else $error("fall top bucket wrong");

    // One check per delay range edge pair
    chk_bucket_direct: assert property (@(posedge core_clk) disable iff (!resetn)
        delayMant <= 7'h06 |-> delayMs == delayMant)
        else $error("direct delay bucket wrong");
    chk_bucket_seven: assert property (@(posedge core_clk) disable iff (!resetn)
        delayMant > 7'h06 && delayMant <= 7'h09 |-> delayMs == 7'h07)
        else $error("bucket 7 wrong");
    chk_bucket_ten: assert property (@(posedge core_clk) disable iff (!resetn)
        delayMant > 7'h09 && delayMant <= 7'h0c |-> delayMs == 7'h0a)
        else $error("bucket 10 wrong");
    chk_bucket_fourteen: assert property (@(posedge core_clk) disable iff (!resetn)
        delayMant > 7'h0c && delayMant <= 7'h11 |-> delayMs == 7'h0e)
        else $error("bucket 14 wrong");
    chk_bucket_nineteen: assert property (@(posedge core_clk) disable iff (!resetn)
        delayMant > 7'h11 && delayMant <= 7'h16 |-> delayMs == 7'h13)
        else $error("bucket 19 wrong");
    chk_bucket_twentyseven: assert property (@(posedge core_clk) disable iff (!resetn)
        delayMant > 7'h16 && delayMant <= 7'h20 |-> delayMs == 7'h1b)
        else $error("bucket 27 wrong");
    chk_bucket_thirtyseven: assert property (@(posedge core_clk) disable iff (!resetn)
        delayMant > 7'h20 && delayMant <= 7'h2c |-> delayMs == 7'h25)
        else $error("bucket 37 wrong");
    chk_bucket_fiftytwo: assert property (@(posedge core_clk) disable iff (!resetn)
        delayMant > 7'h2c && delayMant <= 7'h3e |-> delayMs == 7'h34)
        else $error("bucket 52 wrong");
    chk_bucket_top: assert property (@(posedge core_clk) disable iff (!resetn)
        delayMant > 7'd86 |-> delayMs == 7'd100)
        else $error("top bucket wrong");
    chk_bucket_mid: assert property (@(posedge core_clk) disable iff (!resetn)
        delayMant > 7'd62 && delayMant <= 7'd86 |-> delayMs == 7'd72)
        else $error("bucket 72 wrong");

    chk_tick_bound: assert property (@(posedge core_clk) disable iff (!resetn)
        pre_r <= `TOFS_PRE_W'(CycPerMs - 1))
        else $error("millisecond prescaler overran");
    chk_stop_starts: assert property (@(posedge core_clk) disable iff (!resetn)
        seq_r == TOFS_IDLE && stopReq |=> rampActive)
        else $error("stop did not start turn-off");
    chk_fall_follows: assert property (@(posedge core_clk) disable iff (!resetn)
        seq_r == TOFS_DELAY && msTick && msLeft_r == 7'd1 |=> fallActive)
        else $error("fall did not follow delay");
    chk_fall_ends: assert property (@(posedge core_clk) disable iff (!resetn)
        fallActive && msTick && msLeft_r == 7'h01 |=> !rampActive)
        else $error("fall did not end");
    chk_overvolt_mirror: assert property (@(posedge core_clk) disable iff (!resetn)
        faultSummary[`TOFS_SUM_OVERVOLT] == (output_voltage_status[`TOFS_SRC_BIT] && !loopSlave))
        else $error("overvoltage mirror wrong");
    chk_overcur_mirror: assert property (@(posedge core_clk) disable iff (!resetn)
        faultSummary[`TOFS_SUM_OVERCUR] == output_current_status[`TOFS_SRC_BIT])
        else $error("overcurrent mirror wrong");
    chk_temp_or: assert property (@(posedge core_clk) disable iff (!resetn)
        faultSummary[`TOFS_SUM_TEMP] == |temperature_status)
        else $error("temperature summary wrong");
    chk_comm_or: assert property (@(posedge core_clk) disable iff (!resetn)
        faultSummary[`TOFS_SUM_COMM] == |communication_status)
        else $error("communication summary wrong");
    chk_summary_ignored: assert property (@(posedge core_clk) disable iff (!resetn)
        cmdValid && cmdWrite && (cmdCode == `TOFS_CMD_SUMMARY || cmdCode == `TOFS_CMD_STATUS_WORD) |-> !cmdAck)
        else $error("summary write accepted");
    chk_sum_reserved: assert property (@(posedge core_clk) disable iff (!resetn)
        faultSummary[7] == 1'b0 && faultSummary[3] == 1'b0 && statusWordLow[7:0] == faultSummary)
        else $error("summary layout wrong");
    chk_off_flag: assert property (@(posedge core_clk) disable iff (!resetn)
        faultSummary[`TOFS_SUM_OFF] == !convEnabled)
        else $error("off flag wrong");
    chk_read_answer: assert property (@(posedge core_clk) disable iff (!resetn)
        cmdValid && !cmdWrite && cmdAck |=> cmdRdValid)
        else $error("read not answered next cycle");
    chk_store_copy: assert property (@(posedge core_clk) disable iff (!resetn)
        storeAll |=> nvmWrEn && nvmFallWord == linWord($past(fallMant)))
        else $error("store copy wrong");

    cov_full_seq: cover property (@(posedge core_clk) disable iff (!resetn)
        seq_r == TOFS_FALL ##1 seq_r == TOFS_IDLE);
    cov_nack: cover property (@(posedge core_clk) disable iff (!resetn) cmdNack);
    cov_read: cover property (@(posedge core_clk) disable iff (!resetn) cmdRdValid && rdIsSetting_r);
    cov_status_read: cover property (@(posedge core_clk) disable iff (!resetn) cmdRdValid && !rdIsSetting_r);
    cov_store: cover property (@(posedge core_clk) disable iff (!resetn) nvmWrEn);
endmodule : tofs_turnoff_summary
`default_nettype wire

// [verification/tofs_host_model.sv]
// Host-side model issuing single command transfers to the bank
`default_nettype none
module tofs_host_model (
    input wire logic core_clk,
    input wire logic cmdAck,
    input wire logic cmdNack,
    input wire logic cmdRdValid,
    input wire logic [15:0] cmdRdData,
    output logic cmdValid,
    output logic cmdWrite,
    output logic [7:0] cmdCode,
    output logic [15:0] cmdWrData
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmdValid = 1'b0;
        cmdWrite = 1'b0;
        cmdCode = 8'h00;
        cmdWrData = 16'h0000;
    end
    // One request, held through its taking edge; missing read data returns unknown
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                        output logic ack, output logic nack, output logic [15:0] rd);
        @(posedge core_clk);
        #1;
        cmdValid = 1'b1;
        cmdWrite = wr;
        cmdCode = code;
        cmdWrData = data;
        #5;
        ack = cmdAck;
        nack = cmdNack;
        @(posedge core_clk);
        #1;
        cmdValid = 1'b0;
        cmdCode = ~code;
        cmdWrData = ~data;
        #5;
        rd = cmdRdValid ? cmdRdData : 16'hxxxx;
    endtask : xfer
endmodule : tofs_host_model
`default_nettype wire

// [verification/tofs_turnoff_summary_tb.sv]
// Self-checking bench for the turn-off timing and fault summary bank
`default_nettype none
module tofs_turnoff_summary_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tofs_pkg::*;
    logic core_clk = 1'b0, resetn = 1'b0, loopSlave = 1'b0, storeAll = 1'b0, stopReq = 1'b0, convEnabled = 1'b1;
    logic cmdValid, cmdWrite, cmdAck, cmdNack, cmdRdValid, invalidCmdFault, smbAlertReq, nvmWrEn;
    logic rampActive, fallActive, ack, nack;
    logic [7:0] cmdCode;
    logic [15:0] cmdWrData, cmdRdData, nvmDelayWord, nvmFallWord, statusWordLow, rd;
    logic [6:0] fallMsOut;
    logic [8:0] othSrc = 9'h020;
    tofs_byte_t vs = 8'h00, cs = 8'h00, ts = 8'h00, cm = 8'h00, faultSummary, expSum;
    int numErrors = 0, nCompared = 0, cnt;
    logic [6:0] mants[22] = '{0, 1, 2, 6, 7, 9, 10, 12, 13, 17, 18, 22, 23, 32, 33, 44, 45, 62, 63, 86, 87, 127};
    logic [6:0] fallMs[22] = '{1, 1, 2, 6, 7, 7, 10, 10, 14, 14, 19, 19, 27, 27, 37, 37, 52, 52, 72, 72, 100, 100};
    always #10 core_clk = ~core_clk;
    tofs_host_model u_host (.core_clk(core_clk), .cmdAck(cmdAck), .cmdNack(cmdNack), .cmdRdValid(cmdRdValid),
        .cmdRdData(cmdRdData), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWrData(cmdWrData));
    tofs_turnoff_summary u_dut (.core_clk(core_clk), .resetn(resetn), .loopSlave(loopSlave), .cmdValid(cmdValid),
        .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWrData(cmdWrData), .cmdAck(cmdAck), .cmdNack(cmdNack),
        .cmdRdData(cmdRdData), .cmdRdValid(cmdRdValid), .invalidCmdFault(invalidCmdFault),
        .smbAlertReq(smbAlertReq), .storeAll(storeAll), .nvmWrEn(nvmWrEn), .nvmDelayWord(nvmDelayWord),
        .nvmFallWord(nvmFallWord), .stopReq(stopReq), .rampActive(rampActive), .fallActive(fallActive),
        .fallMsOut(fallMsOut), .convEnabled(convEnabled), .output_voltage_status(vs), .output_current_status(cs),
        .temperature_status(ts), .communication_status(cm), .undervoltFault(othSrc[0]),
        .overcurrentWarn(othSrc[1]), .overvoltWarn(othSrc[2]), .undervoltWarn(othSrc[3]),
        .turn_on_timeout_fault(othSrc[4]), .lowInputVoltage(othSrc[5]), .setpoint_limit_warning(othSrc[6]),
        .bandgap_overtemp_fault(othSrc[7]), .internal_supply_fault(othSrc[8]), .faultSummary(faultSummary),
        .statusWordLow(statusWordLow));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        nCompared++;
        if (seen !== exp) begin
            numErrors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize;
        if (numErrors == 0 && nCompared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    // Expected summary built bit by bit from the source levels
    task automatic sumChk;
        expSum = {1'b0, ~convEnabled, vs[7] & ~loopSlave, cs[7], 1'b0, |ts, |cm, |othSrc};
        #5;
        check({8'h00, faultSummary}, {8'h00, expSum});
        check(statusWordLow, {8'h00, expSum});
        u_host.xfer(1'b0, 8'h78, 16'h0000, ack, nack, rd);
        check(rd, {8'h00, expSum});
        u_host.xfer(1'b0, 8'h79, 16'h0000, ack, nack, rd);
        check(rd, {8'h00, expSum});
    endtask : sumChk
    initial begin
        repeat (10) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        sumChk();
        u_host.xfer(1'b0, 8'h64, 16'h0000, ack, nack, rd);
        check(rd, 16'h0000);
        u_host.xfer(1'b0, 8'h65, 16'h0000, ack, nack, rd);
        check(rd, 16'h0000);
        check({9'h000, fallMsOut}, 16'h0001);
        for (int i = 0; i < 22; i++) begin
            // Upper bits set on purpose: exponent and top mantissa must not stick
            u_host.xfer(1'b1, 8'h65, {9'h1ff, mants[i]}, ack, nack, rd);
            check({15'h0000, ack}, 16'h0001);
            u_host.xfer(1'b0, 8'h65, 16'h0000, ack, nack, rd);
            check(rd, {9'h000, mants[i]});
            u_host.xfer(1'b1, 8'h64, {9'h1ff, mants[i]}, ack, nack, rd);
            u_host.xfer(1'b0, 8'h64, 16'h0000, ack, nack, rd);
            check(rd, {9'h000, mants[i]});
            check({9'h000, fallMsOut}, {9'h000, fallMs[i]});
        end
        @(posedge core_clk);
        #1;
        storeAll = 1'b1;
        @(posedge core_clk);
        #1;
        storeAll = 1'b0;
        #4;
        check({15'h0000, nvmWrEn}, 16'h0001);
        check(nvmDelayWord, 16'h007f);
        check(nvmFallWord, 16'h007f);
        u_host.xfer(1'b1, 8'h78, 16'h00ff, ack, nack, rd);
        check({15'h0000, ack}, 16'h0000);
        for (int k = 0; k < 9; k++) begin
            othSrc = 9'h001 << k;
            vs = 8'h01 << k[2:0];
            cs = ~vs;
            ts = (k == 8) ? 8'h00 : 8'h80 >> k;
            cm = (k > 4) ? 8'h04 : 8'h00;
            convEnabled = k[0];
            sumChk();
        end
        loopSlave = 1'b1;
        vs = 8'h80;
        sumChk();
        u_host.xfer(1'b1, 8'h64, 16'h0005, ack, nack, rd);
        check({14'h0000, ack, nack}, 16'h0001);
        check({14'h0000, invalidCmdFault, smbAlertReq}, 16'h0003);
        u_host.xfer(1'b0, 8'h65, 16'h0000, ack, nack, rd);
        check({15'h0000, nack}, 16'h0001);
        loopSlave = 1'b0;
        vs = 8'h00;
        othSrc = 9'h000;
        cs = 8'h00;
        sumChk();
        u_host.xfer(1'b0, 8'h64, 16'h0000, ack, nack, rd);
        check(rd, 16'h007f);
        // Mid-run reset must bring both mantissas back to zero
        @(posedge core_clk);
        #1;
        resetn = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        u_host.xfer(1'b0, 8'h64, 16'h0000, ack, nack, rd);
        check(rd, 16'h0000);
        u_host.xfer(1'b0, 8'h65, 16'h0000, ack, nack, rd);
        check(rd, 16'h0000);
        check({9'h000, fallMsOut}, 16'h0001);
        u_host.xfer(1'b1, 8'h64, 16'h0000, ack, nack, rd);
        u_host.xfer(1'b1, 8'h65, 16'h0000, ack, nack, rd);
        @(posedge core_clk);
        #1;
        stopReq = 1'b1;
        @(posedge core_clk);
        #1;
        stopReq = 1'b0;
        #4;
        check({15'h0000, rampActive}, 16'h0001);
        cnt = 0;
        // Zero delay, zero fall: one millisecond of falling, no more
        // Bounded by cycles, not by fall count, so a stuck delay phase still ends
        for (int w = 0; w < 60000 && rampActive === 1'b1; w++) begin
            @(posedge core_clk);
            #1;
            cnt += fallActive ? 1 : 0;
        end
        check({15'h0000, rampActive}, 16'h0000);
        check({15'h0000, cnt >= 49999 && cnt <= 50001}, 16'h0001);
        check({15'h0000, fallActive}, 16'h0000);
        summarize();
    end
endmodule : tofs_turnoff_summary_tb
`default_nettype wire
